// ===== common/dlsw_regs.vh
/*
 dlsw_regs.vh: register offsets, field positions, reset values, command codes
 and timing counts of the dll mode switch sequencer.
 assumes hclk at 125 MHz and a memory clock made by dividing hclk.
*/
`ifndef DLSW_REGS_VH
`define DLSW_REGS_VH

// register byte offsets
`define DLSW_OFF_CTRL    8'h00
`define DLSW_OFF_DIV     8'h04
`define DLSW_OFF_MR0     8'h08
`define DLSW_OFF_MR1     8'h0C
`define DLSW_OFF_MR2     8'h10
`define DLSW_OFF_STAT    8'h14

// field positions
`define DLSW_CTRL_START  0
`define DLSW_CTRL_DIR    1
`define DLSW_CTRL_ZQ     2
`define DLSW_STAT_BUSY   0
`define DLSW_STAT_DONE   1
`define DLSW_STAT_DLLON  2
`define DLSW_MR1_DLLOFF  0
`define DLSW_MR0_DLLRST  8
`define DLSW_ADDR_AP     10

// reset values
`define DLSW_DIV_RST     8'h04
`define DLSW_MR_RST      14'h0000

// latency fields forced for dll-off operation
`define DLSW_MR0_CL_MASK  14'h0074
`define DLSW_MR0_CL6      14'h0020
`define DLSW_MR2_CWL_MASK 14'h0038
`define DLSW_MR2_CWL6     14'h0008

// mode register selects on the bank address
`define DLSW_BA_MR0      3'h0
`define DLSW_BA_MR1      3'h1
`define DLSW_BA_MR2      3'h2

// command codes {cs_n, ras_n, cas_n, we_n}
`define DLSW_CMD_NOP     4'h7
`define DLSW_CMD_DES     4'hF
`define DLSW_CMD_MRS     4'h0
`define DLSW_CMD_REF     4'h1
`define DLSW_CMD_PRE     4'h2
`define DLSW_CMD_ZQ      4'h6

// timings in memory clock cycles
`define DLSW_TMRD_NCK    16'h0004
`define DLSW_TMOD_NCK    16'h000C
`define DLSW_TRP_NCK     16'h0008
`define DLSW_TCKSRE_NCK  16'h0005
`define DLSW_TCKSRX_NCK  16'h0005
`define DLSW_TDLLK_NCK   16'h0200
`define DLSW_TZQOPER_NCK 16'h0200

// timings in ns, converted to hclk cycles rounding up
`define DLSW_HCLK_PS     8000
`define DLSW_TXS_NS      170
`define DLSW_TXS_CYC     ((`DLSW_TXS_NS * 1000 + `DLSW_HCLK_PS - 1) / `DLSW_HCLK_PS)

`endif

// ===== rtl/dlsw_ctrl.v
/*
 dlsw_ctrl.v: controller that switches a ddr3l memory between dll-off and
 dll-on operation with a clock change in self refresh, under ahb-lite control.
 assumes a single ahb-lite master, one memory on the pins, and that the memory
 is idle with no pending timings when software starts a switch.
*/
// How it works
// - precharge all banks and keep odt low before self refresh entry
// - enter self refresh and wait tCKSRE before changing the clock divider
// - run the new clock stable for tCKSRX before self refresh exit
// - cke stays high from self refresh exit until tDLLK after dll reset
// - odt is held low across the whole re-enable sequence
// - odt low is one legal choice when termination was off
// - after tXS write mode register 1 with A0 cleared
// - tMRD later write mode register 0 with A8 set for dll reset
// - tMRD later write mode register 2 with new latency settings
// - long zq calibration only after tMOD from the last mode write
// - ready after tMOD, and not before tDLLK from dll reset
// - wait tZQoper as well when long zq calibration was issued
// - cycle spacings count real memory clock rising edges
// - ns timings convert to cycles by rounding up
// - dll-off switch starts idle, odt low, writes mode register 1 A0 set
// - dll-off switch exits self refresh then rewrites mode registers
// - dll-off settings force cas latency six and write latency six
`timescale 1ns/1ps
`default_nettype none
`include "dlsw_regs.vh"
module dlsw_ctrl (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [7:0]  haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   // memory pins
   output reg         ck_p,
   output reg         ck_n,
   output reg         cke,
   output reg         cs_n,
   output reg         ras_n,
   output reg         cas_n,
   output reg         we_n,
   output reg  [2:0]  ba,
   output reg  [13:0] addr,
   output reg         odt
);
   localparam [12:0] S_IDLE = 13'h0001;
   localparam [12:0] S_PRE  = 13'h0002;
   localparam [12:0] S_DIS  = 13'h0004;
   localparam [12:0] S_SRE  = 13'h0008;
   localparam [12:0] S_CHG  = 13'h0010;
   localparam [12:0] S_SRX  = 13'h0020;
   localparam [12:0] S_EN   = 13'h0040;
   localparam [12:0] S_RST  = 13'h0080;
   localparam [12:0] S_MR0  = 13'h0100;
   localparam [12:0] S_MR2  = 13'h0200;
   localparam [12:0] S_ZQ   = 13'h0400;
   localparam [12:0] S_FIN  = 13'h0800;
   localparam [12:0] S_WAIT = 13'h1000;

   // ahb side
   reg        wr_q;
   reg  [7:0] adr_q;
   reg        dir_q;
   reg        zq_q;
   reg  [7:0] div_q;
   reg  [13:0] mr0_q;
   reg  [13:0] mr1_q;
   reg  [13:0] mr2_q;
   reg        done_q;
   reg        dllon_q;
   reg        start_q;
   // sequencer
   reg  [12:0] state_q;
   reg  [12:0] ret_q;
   reg        zq_used_q;
   reg  [7:0] half_q;
   reg  [7:0] hcnt_q;
   reg        ck_rise;
   reg        ck_fall;
   reg        ld_step;
   reg  [15:0] step_val;
   reg        step_nck_q;
   reg        ld_dllk;
   reg        ld_zq;
   reg        fin_evt;
   wire       step_zero;
   wire       dllk_zero;
   wire       zqt_zero;
   wire       addr_ph;
   wire [31:0] rd_val;
   wire [31:0] txs_cyc;

   function [7:0] dlsw_half;
      input [7:0] v;
      begin
         dlsw_half = (v == 8'h00) ? 8'h01 : v;
      end
   endfunction

   function [31:0] dlsw_read;
      input [7:0] a;
      begin
         if (a == `DLSW_OFF_CTRL) begin
            dlsw_read = {29'h0, zq_q, dir_q, 1'b0};
         end else if (a == `DLSW_OFF_DIV) begin
            dlsw_read = {16'h0, half_q, div_q};
         end else if (a == `DLSW_OFF_MR0) begin
            dlsw_read = {18'h0, mr0_q};
         end else if (a == `DLSW_OFF_MR1) begin
            dlsw_read = {18'h0, mr1_q};
         end else if (a == `DLSW_OFF_MR2) begin
            dlsw_read = {18'h0, mr2_q};
         end else if (a == `DLSW_OFF_STAT) begin
            dlsw_read = {3'h0, state_q, 13'h0, dllon_q, done_q, (state_q != S_IDLE)};
         end else begin
            dlsw_read = 32'h0000_0000;
         end
      end
   endfunction

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_ph   = hsel && hready && htrans[1];
   assign rd_val    = dlsw_read(haddr);
   assign txs_cyc   = `DLSW_TXS_CYC;

   // bus slave: address phase latched, write in data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q    <= 1'b0;
         adr_q   <= 8'h00;
         hrdata  <= 32'h0000_0000;
         dir_q   <= 1'b0;
         zq_q    <= 1'b0;
         div_q   <= `DLSW_DIV_RST;
         mr0_q   <= `DLSW_MR_RST;
         mr1_q   <= `DLSW_MR_RST;
         mr2_q   <= `DLSW_MR_RST;
         start_q <= 1'b0;
         done_q  <= 1'b0;
      end else begin
         wr_q    <= addr_ph && hwrite;
         // start pends until the next clock fall; ignored while a switch runs
         if (ck_fall && state_q == S_IDLE && start_q) begin
            start_q <= 1'b0;
         end else if (wr_q && adr_q == `DLSW_OFF_CTRL && hwdata[`DLSW_CTRL_START]
                      && state_q == S_IDLE) begin
            start_q <= 1'b1;
         end
         if (addr_ph) begin
            adr_q <= haddr;
         end
         if (addr_ph && !hwrite) begin
            hrdata <= rd_val;
         end
         if (wr_q) begin
            if (adr_q == `DLSW_OFF_CTRL) begin
               dir_q   <= hwdata[`DLSW_CTRL_DIR];
               zq_q    <= hwdata[`DLSW_CTRL_ZQ];
            end else if (adr_q == `DLSW_OFF_DIV) begin
               div_q <= hwdata[7:0];
            end else if (adr_q == `DLSW_OFF_MR0) begin
               mr0_q <= hwdata[13:0];
            end else if (adr_q == `DLSW_OFF_MR1) begin
               mr1_q <= hwdata[13:0];
            end else if (adr_q == `DLSW_OFF_MR2) begin
               mr2_q <= hwdata[13:0];
            end
         end
         // set wins over the write-one clear
         if (fin_evt) begin
            done_q <= 1'b1;
         end else if (wr_q && adr_q == `DLSW_OFF_STAT && hwdata[`DLSW_STAT_DONE]) begin
            done_q <= 1'b0;
         end
      end
   end

   // memory clock divider; command pins change on the falling edge
   always @* begin
      ck_rise = (hcnt_q == half_q - 8'h01) && !ck_p;
      ck_fall = (hcnt_q == half_q - 8'h01) && ck_p;
   end

   dlsw_timer u_step (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .load     (ld_step),
      .load_val (step_val),
      .tick     (step_nck_q ? ck_rise : 1'b1),
      .zero     (step_zero)
   );

   dlsw_timer u_dllk (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .load     (ld_dllk),
      .load_val (`DLSW_TDLLK_NCK),
      .tick     (ck_rise),
      .zero     (dllk_zero)
   );

   dlsw_timer u_zq (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .load     (ld_zq),
      .load_val (`DLSW_TZQOPER_NCK),
      .tick     (ck_rise),
      .zero     (zqt_zero)
   );

   // which counter load each step issues
   always @* begin
      ld_step  = 1'b0;
      step_val = `DLSW_TMRD_NCK;
      ld_dllk  = 1'b0;
      ld_zq    = 1'b0;
      fin_evt  = 1'b0;
      if (ck_fall) begin
         case (state_q)
            S_PRE: begin
               ld_step  = 1'b1;
               step_val = `DLSW_TRP_NCK;
            end
            S_DIS: begin
               ld_step  = 1'b1;
               step_val = `DLSW_TMOD_NCK;
            end
            S_SRE: begin
               ld_step  = 1'b1;
               step_val = `DLSW_TCKSRE_NCK;
            end
            S_CHG: begin
               ld_step  = 1'b1;
               step_val = `DLSW_TCKSRX_NCK;
            end
            S_SRX: begin
               ld_step  = 1'b1;
               step_val = txs_cyc[15:0];
            end
            S_EN: begin
               ld_step = 1'b1;
            end
            S_RST: begin
               ld_step = 1'b1;
               ld_dllk = 1'b1;
            end
            S_MR0: begin
               ld_step = 1'b1;
            end
            S_MR2: begin
               ld_step  = 1'b1;
               step_val = `DLSW_TMOD_NCK;
            end
            S_ZQ: begin
               ld_zq = zq_q;
            end
            S_FIN: begin
               fin_evt = dllk_zero && (zqt_zero || !zq_used_q);
            end
            default: begin
               ld_step = 1'b0;
            end
         endcase
      end
   end

   // sequencer and pins
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q    <= S_IDLE;
         ret_q      <= S_IDLE;
         zq_used_q  <= 1'b0;
         dllon_q    <= 1'b1;
         step_nck_q <= 1'b1;
         half_q     <= `DLSW_DIV_RST;
         hcnt_q     <= 8'h00;
         ck_p       <= 1'b0;
         ck_n       <= 1'b1;
         cke        <= 1'b1;
         {cs_n, ras_n, cas_n, we_n} <= `DLSW_CMD_DES;
         ba         <= 3'h0;
         addr       <= 14'h0000;
         odt        <= 1'b0;
      end else begin
         if (ck_rise || ck_fall) begin
            hcnt_q <= 8'h00;
            ck_p   <= ~ck_p;
            ck_n   <= ~ck_n;
         end else begin
            hcnt_q <= hcnt_q + 8'h01;
         end
         if (ck_fall) begin
            {cs_n, ras_n, cas_n, we_n} <= `DLSW_CMD_NOP;
            addr <= 14'h0000;
            ba   <= 3'h0;
            case (state_q)
               S_IDLE: begin
                  {cs_n, ras_n, cas_n, we_n} <= `DLSW_CMD_DES;
                  if (start_q) begin
                     state_q   <= S_PRE;
                     zq_used_q <= 1'b0;
                  end
               end
               S_PRE: begin
                  {cs_n, ras_n, cas_n, we_n} <= `DLSW_CMD_PRE;
                  addr[`DLSW_ADDR_AP] <= 1'b1;
                  step_nck_q <= 1'b1;
                  state_q <= S_WAIT;
                  ret_q   <= dir_q ? S_DIS : S_SRE;
               end
               S_DIS: begin
                  {cs_n, ras_n, cas_n, we_n} <= `DLSW_CMD_MRS;
                  ba   <= `DLSW_BA_MR1;
                  addr <= mr1_q | 14'h0001;
                  dllon_q <= 1'b0;
                  state_q <= S_WAIT;
                  ret_q   <= S_SRE;
               end
               S_SRE: begin
                  {cs_n, ras_n, cas_n, we_n} <= `DLSW_CMD_REF;
                  cke     <= 1'b0;
                  state_q <= S_WAIT;
                  ret_q   <= S_CHG;
               end
               S_CHG: begin
                  half_q  <= dlsw_half(div_q);
                  state_q <= S_WAIT;
                  ret_q   <= S_SRX;
               end
               S_SRX: begin
                  cke        <= 1'b1;
                  step_nck_q <= 1'b0;
                  state_q    <= S_WAIT;
                  ret_q      <= dir_q ? S_MR0 : S_EN;
               end
               S_EN: begin
                  {cs_n, ras_n, cas_n, we_n} <= `DLSW_CMD_MRS;
                  ba   <= `DLSW_BA_MR1;
                  addr <= mr1_q & 14'h3FFE;
                  step_nck_q <= 1'b1;
                  dllon_q <= 1'b1;
                  state_q <= S_WAIT;
                  ret_q   <= S_RST;
               end
               S_RST: begin
                  {cs_n, ras_n, cas_n, we_n} <= `DLSW_CMD_MRS;
                  ba   <= `DLSW_BA_MR0;
                  addr <= mr0_q | 14'h0100;
                  state_q <= S_WAIT;
                  ret_q   <= S_MR2;
               end
               S_MR0: begin
                  {cs_n, ras_n, cas_n, we_n} <= `DLSW_CMD_MRS;
                  ba   <= `DLSW_BA_MR0;
                  addr <= (mr0_q & ~`DLSW_MR0_CL_MASK) | `DLSW_MR0_CL6;
                  step_nck_q <= 1'b1;
                  state_q <= S_WAIT;
                  ret_q   <= S_MR2;
               end
               S_MR2: begin
                  {cs_n, ras_n, cas_n, we_n} <= `DLSW_CMD_MRS;
                  ba <= `DLSW_BA_MR2;
                  if (dir_q) begin
                     addr <= (mr2_q & ~`DLSW_MR2_CWL_MASK) | `DLSW_MR2_CWL6;
                  end else begin
                     addr <= mr2_q;
                  end
                  state_q <= S_WAIT;
                  ret_q   <= S_ZQ;
               end
               S_ZQ: begin
                  if (zq_q) begin
                     {cs_n, ras_n, cas_n, we_n} <= `DLSW_CMD_ZQ;
                     addr[`DLSW_ADDR_AP] <= 1'b1;
                     zq_used_q <= 1'b1;
                  end
                  state_q <= S_FIN;
               end
               S_FIN: begin
                  if (fin_evt) begin
                     state_q <= S_IDLE;
                  end
               end
               S_WAIT: begin
                  if (step_zero) begin
                     state_q <= ret_q;
                  end
               end
               default: begin
                  state_q <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ===== rtl/dlsw_timer.v
/*
 dlsw_timer.v: loadable down counter that expires after a number of ticks.
 assumes load and tick come from logic on hclk.
*/
`timescale 1ns/1ps
`default_nettype none
module dlsw_timer (
   // clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // control
   input  wire        load,
   input  wire [15:0] load_val,
   input  wire        tick,
   // status
   output wire        zero
);
   reg [15:0] cnt_q;
   reg [15:0] cnt_d;

   always @* begin
      cnt_d = cnt_q;
      if (load) begin
         cnt_d = load_val;
      end else if (tick && cnt_q != 16'h0000) begin
         cnt_d = cnt_q - 16'h0001;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign zero = (cnt_q == 16'h0000);
endmodule
`default_nettype wire

// ===== sim/dlsw_ctrl_sva.sv
/* dlsw_ctrl_sva.sv: pin sequence checker for the dll switch controller.
   assumes the ports of dlsw_ctrl and the timing counts of dlsw_regs.vh. */
`timescale 1ns/1ps
`default_nettype none
`include "dlsw_regs.vh"
module dlsw_chk (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // memory pins
   input wire logic ck_p,
   input wire logic ck_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic odt
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire  [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   logic [3:0] cmd_q;
   logic [7:0] gap_q;
   logic [7:0] xs_q;
   logic       ckp_q;
   logic       cke_q;
   logic       pre_q;
   wire        mrs_new = cmd == `DLSW_CMD_MRS && cmd_q != `DLSW_CMD_MRS;
   wire        zq_new  = cmd == `DLSW_CMD_ZQ && cmd_q != `DLSW_CMD_ZQ;
   // memory clock rises since the last mode write, hclk since self refresh exit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_q <= `DLSW_CMD_DES;
         gap_q <= 8'hFF;
         xs_q  <= 8'hFF;
         ckp_q <= 1'h0;
         cke_q <= 1'h1;
         pre_q <= 1'h0;
      end else begin
         cmd_q <= cmd;
         ckp_q <= ck_p;
         cke_q <= cke;
         if (mrs_new)
            gap_q <= 8'h00;
         else if (ck_p && !ckp_q && gap_q != 8'hFF)
            gap_q <= gap_q + 8'h01;
         if (cke && !cke_q)
            xs_q <= 8'h01;
         else if (xs_q != 8'hFF)
            xs_q <= xs_q + 8'h01;
         if (cmd == `DLSW_CMD_PRE)
            pre_q <= 1'h1;
         else if (!cke && cke_q)
            pre_q <= 1'h0;
      end
   end
   a_odt_low: assert property (odt == 1'h0)
      else $error("odt driven high");
   a_ck_pair: assert property (ck_n == !ck_p)
      else $error("clock pair not complementary");
   a_cmd_fall: assert property ($changed(cmd) |-> $fell(ck_p))
      else $error("command changed away from a clock fall");
   a_cke_fall: assert property ($changed(cke) |-> $fell(ck_p))
      else $error("clock enable changed away from a clock fall");
   a_sre_ref: assert property ($fell(cke) |-> cmd == `DLSW_CMD_REF)
      else $error("clock enable dropped without self refresh");
   a_sre_prea: assert property ($fell(cke) |-> pre_q)
      else $error("self refresh entered without precharge");
   a_srx_nop: assert property ($rose(cke) |-> cmd == `DLSW_CMD_NOP)
      else $error("self refresh exit without nop");
   a_cke_hold: assert property ($rose(cke) |=> cke [*8])
      else $error("clock enable dropped after exit");
   a_mrs_gap: assert property (mrs_new |-> gap_q >= `DLSW_TMRD_NCK)
      else $error("mode writes too close");
   a_zq_gap: assert property (zq_new |-> gap_q >= `DLSW_TMOD_NCK)
      else $error("calibration too soon after mode write");
   a_xs_wait: assert property (mrs_new |-> xs_q >= `DLSW_TXS_CYC)
      else $error("mode write too soon after exit");
   c_sre: cover property ($fell(cke));
   c_srx: cover property ($rose(cke));
   c_zq: cover property (zq_new);
endmodule
bind dlsw_ctrl dlsw_chk u_chk (.hclk, .hresetn, .ck_p, .ck_n, .cke, .cs_n, .ras_n,
   .cas_n, .we_n, .odt);
`default_nettype wire

// ===== sim/dlsw_ctrl_tb.sv
/* dlsw_ctrl_tb.sv: self-checking bench for the dll switch controller.
   assumes dlsw_ctrl, the memory model dlsw_mem and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "dlsw_regs.vh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
   $display("mismatch at %0t: got %0h exp %0h", $time, got, exp); end end
module dlsw_ctrl_tb;
   localparam logic [31:0] M0 = 32'h00000A54;
   localparam logic [31:0] M1 = 32'h00000046;
   localparam logic [31:0] M2 = 32'h00000030;
   logic        hclk, hresetn, hsel, hwrite;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, rd;
   wire         hready, hresp, ck_p, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, dll_on;
   wire  [31:0] hrdata;
   wire  [2:0]  ba;
   wire  [13:0] addr, mr0, mr1, mr2;
   wire  [7:0]  n_srx, n_zq, viol;
   wire  [15:0] per_ns;
   int          errors, n_checks;
   dlsw_ctrl DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .ck_p, .ck_n, .cke,
      .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .odt);
   dlsw_mem MEM (.ck_p, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr, .mr0_q(mr0),
      .mr1_q(mr1), .mr2_q(mr2), .dll_on_q(dll_on), .n_srx_q(n_srx), .n_zq_q(n_zq),
      .viol_q(viol), .per_ns);
   initial begin
      hclk = 1'h0;
      forever #4 hclk = ~hclk;
   end
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'h1);
      rd = hrdata;
   endtask
   task automatic go(input logic [31:0] c);
      int i;
      i = 0;
      do begin
         ahb(1'h1, `DLSW_OFF_CTRL, c);
         ahb(1'h0, `DLSW_OFF_STAT, 32'h0);
         i++;
      end while (rd[`DLSW_STAT_BUSY] !== 1'h1 && i < 64);
   endtask
   task automatic run(input logic [31:0] c, input longint lo);
      int  i;
      time t0;
      go(c);
      t0 = $time;
      ahb(1'h1, `DLSW_OFF_CTRL, c);
      i = 0;
      do begin
         ahb(1'h0, `DLSW_OFF_STAT, 32'h0);
         i++;
      end while (rd[`DLSW_STAT_DONE] !== 1'h1 && i < 9000);
      `CHK(rd[2:0], {~c[1], 2'h2})
      `CHK($time - t0 >= lo, 1'h1)
      ahb(1'h1, `DLSW_OFF_STAT, 32'h2);
      ahb(1'h0, `DLSW_OFF_STAT, 32'h0);
      `CHK(rd[1], 1'h0)
   endtask
   task automatic t_regs;
      ahb(1'h0, `DLSW_OFF_STAT, 32'h0);
      `CHK(rd[2:0], 3'h4)
      `CHK(hresp, 1'h0)
      ahb(1'h0, `DLSW_OFF_DIV, 32'h0);
      `CHK(rd[15:0], 16'h0404)
      ahb(1'h1, `DLSW_OFF_MR2, 32'hFFFFFFFF);
      ahb(1'h1, 8'h18, 32'hFFFFFFFF);
      ahb(1'h0, `DLSW_OFF_MR2, 32'h0);
      `CHK(rd, 32'h00003FFF)
      ahb(1'h0, 8'h18, 32'h0);
      `CHK(rd, 32'h0)
   endtask
   task automatic t_off;
      ahb(1'h1, `DLSW_OFF_MR0, M0);
      ahb(1'h1, `DLSW_OFF_MR1, M1);
      ahb(1'h1, `DLSW_OFF_MR2, M2);
      ahb(1'h1, `DLSW_OFF_DIV, 32'h8);
      run(32'h3, `DLSW_TMOD_NCK * 128);
      `CHK(mr1, M1[13:0] | 14'h1)
      `CHK(mr0, (M0[13:0] & ~`DLSW_MR0_CL_MASK) | `DLSW_MR0_CL6)
      `CHK(mr2, (M2[13:0] & ~`DLSW_MR2_CWL_MASK) | `DLSW_MR2_CWL6)
      `CHK({dll_on, n_srx, viol}, 17'h00100)
      `CHK(per_ns, 16'h0080)
   endtask
   task automatic t_on;
      ahb(1'h1, `DLSW_OFF_DIV, 32'h0);
      run(32'h5, `DLSW_TDLLK_NCK * 16);
      `CHK(mr1, M1[13:0])
      `CHK(mr0, M0[13:0] | 14'h0100)
      `CHK(mr2, M2[13:0])
      `CHK({dll_on, n_srx, n_zq, viol}, 25'h1020100)
      `CHK(per_ns, 16'h0010)
      ahb(1'h0, `DLSW_OFF_DIV, 32'h0);
      `CHK(rd[15:8], 8'h01)
   endtask
   task automatic t_rst;
      ahb(1'h1, `DLSW_OFF_DIV, 32'h6);
      go(32'h3);
      repeat (10) @(posedge hclk);
      hresetn <= 1'h0;
      @(posedge hclk);
      #1;
      `CHK({cke, cs_n, ras_n, cas_n, we_n, odt}, 6'h3E)
      @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      ahb(1'h0, `DLSW_OFF_STAT, 32'h0);
      `CHK(rd[2:0], 3'h4)
   endtask
   initial begin
      #200us;
      errors++;
      $display("watchdog expired at %0t", $time);
      stop_test;
   end
   initial begin
      hresetn = 1'h0;
      hsel = 1'h0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'h0;
      hwdata = 32'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      t_regs;
      t_off;
      t_on;
      t_rst;
      stop_test;
   end
endmodule
`default_nettype wire

// ===== sim/dlsw_mem_model.sv
/* dlsw_mem_model.sv: behavioural memory that decodes commands on clock rises.
   assumes commands settle before each rise; outputs are for the bench only. */
`timescale 1ns/1ps
`default_nettype none
`include "dlsw_regs.vh"
module dlsw_mem (
   // memory pins
   input  wire logic        ck_p,
   input  wire logic        cke,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic [2:0]  ba,
   input  wire logic [13:0] addr,
   // observed state
   output var  logic [13:0] mr0_q,
   output var  logic [13:0] mr1_q,
   output var  logic [13:0] mr2_q,
   output var  logic        dll_on_q,
   output var  logic [7:0]  n_srx_q,
   output var  logic [7:0]  n_zq_q,
   output var  logic [7:0]  viol_q,
   output var  logic [15:0] per_ns
);
   wire  [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   logic       sr_q = 1'h0;
   logic       cke_q = 1'h1;
   logic [7:0] gap_q = 8'hFF;
   realtime    t_q = 0.0;
   initial begin
      {mr0_q, mr1_q, mr2_q, n_srx_q, n_zq_q, viol_q, per_ns} = '0;
      dll_on_q = 1'h1;
   end
   always @(posedge ck_p) begin
      per_ns <= 16'($rtoi($realtime - t_q));
      t_q <= $realtime;
      cke_q <= cke;
      gap_q <= (gap_q == 8'hFF) ? gap_q : gap_q + 8'h01;
      if (cke_q && !cke && cmd == `DLSW_CMD_REF)
         sr_q <= 1'h1;
      if (sr_q && cke) begin
         sr_q <= 1'h0;
         n_srx_q <= n_srx_q + 8'h01;
      end
      if (cke && cmd == `DLSW_CMD_ZQ)
         n_zq_q <= n_zq_q + 8'h01;
      if (cmd == `DLSW_CMD_MRS) begin
         gap_q <= 8'h01;
         if (sr_q || gap_q < `DLSW_TMRD_NCK)
            viol_q <= viol_q + 8'h01;
         if (mr1_q[0] && ((ba == `DLSW_BA_MR0 && (addr & `DLSW_MR0_CL_MASK) != `DLSW_MR0_CL6)
             || (ba == `DLSW_BA_MR2 && (addr & `DLSW_MR2_CWL_MASK) != `DLSW_MR2_CWL6)))
            viol_q <= viol_q + 8'h01;
         case (ba)
            `DLSW_BA_MR0: mr0_q <= addr;
            `DLSW_BA_MR1: begin
               mr1_q <= addr;
               dll_on_q <= !addr[0];
            end
            `DLSW_BA_MR2: mr2_q <= addr;
            default: ;
         endcase
      end
   end
endmodule
`default_nettype wire
